// ---- verilog/tsc_timer.sv ----
// Top of the 16-bit timer/counter with Avalon-MM register access.
`timescale 1ns/1ps
`default_nettype none
`include "tsc_map.svh"
module tsc_timer (
    input  wire logic        ref_clk_i,
    input  wire logic        rst_i,
    input  wire logic        soft_rst_i,
    input  wire logic        sleep_i,
    input  wire logic        adc_enable_i,
    input  wire logic        ext_clock_pin_i,
    input  wire logic        osc_input_pin_i,
    input  wire logic [4:0]  address_i,
    input  wire logic        read_i,
    input  wire logic        write_i,
    input  wire logic [3:0]  byteenable_i,
    input  wire logic [31:0] writedata_i,
    output var  logic [31:0] readdata_o,
    output var  logic        waitrequest_o,
    output var  logic        osc_enable_o,
    output var  logic        overflow_irq_o,
    output var  logic        adc_start_o,
    output var  logic        timebase_valid_o
);

    // ============================================================
    // Register state
    logic [6:0]           control;
    tsc_pkg::tsc_count_t  count;
    logic [7:0]           cmp_lo;
    logic [7:0]           cmp_hi;
    logic [3:0]           cmp_mode;
    logic                 ovf_flag;
    tsc_pkg::tsc_bus_state_t bus_state;

    // ============================================================
    // Control fields
    logic       counter_on;
    logic       clock_source_select;
    logic       sync_disable;
    logic       crystal_osc_enable;
    logic [1:0] prescale_field;

    assign counter_on          = control[`TSC_BIT_ON];
    assign clock_source_select = control[`TSC_BIT_CS];
    assign sync_disable        = control[`TSC_BIT_SYNC_DIS];
    assign crystal_osc_enable  = control[`TSC_BIT_OSC_EN];
    assign prescale_field      = control[`TSC_BIT_PS_HI:`TSC_BIT_PS_LO];

    // Asynchronous counter mode: external source, not resynchronised.
    logic async_mode;
    assign async_mode = clock_source_select && sync_disable;

    // ============================================================
    // Bus decode
    logic wr_fire;
    logic wr_lo;
    logic wr_hi;
    logic wr_ctl;
    logic wr_cmp_lo;
    logic wr_cmp_hi;
    logic wr_mode;
    logic wr_stat;

    // A write acts at the edge where waitrequest is seen low.
    assign wr_fire = (bus_state == tsc_pkg::TSC_BUS_ANSWER) && write_i && byteenable_i[0];

    // Address decoding for writes.
    always_comb
    begin
        wr_lo     = 1'b0;
        wr_hi     = 1'b0;
        wr_ctl    = 1'b0;
        wr_cmp_lo = 1'b0;
        wr_cmp_hi = 1'b0;
        wr_mode   = 1'b0;
        wr_stat   = 1'b0;
        if (address_i == `TSC_OFS_COUNT_LO)
            wr_lo = wr_fire;
        else if (address_i == `TSC_OFS_COUNT_HI)
            wr_hi = wr_fire;
        else if (address_i == `TSC_OFS_CONTROL)
            wr_ctl = wr_fire;
        else if (address_i == `TSC_OFS_CMP_LO)
            wr_cmp_lo = wr_fire;
        else if (address_i == `TSC_OFS_CMP_HI)
            wr_cmp_hi = wr_fire;
        else if (address_i == `TSC_OFS_CMP_MODE)
            wr_mode = wr_fire;
        else if (address_i == `TSC_OFS_STATUS)
            wr_stat = wr_fire;
    end

    // ============================================================
    // Pin synchronisers
    logic ext_sync;
    logic osc_sync;

    tsc_sync2 u_ext_sync (
        .ref_clk_i (ref_clk_i),
        .d_i       (ext_clock_pin_i),
        .q_o       (ext_sync)
    );

    tsc_sync2 u_osc_sync (
        .ref_clk_i (ref_clk_i),
        .d_i       (osc_input_pin_i),
        .q_o       (osc_sync)
    );

    // ============================================================
    // Source selection and edge detection
    logic src_level;
    logic src_level_q;
    logic src_rise;
    logic src_fall;
    logic armed;

    // The crystal pin is the source whenever the oscillator is on.
    assign src_level = crystal_osc_enable ? osc_sync : ext_sync;
    assign src_rise  = src_level && !src_level_q;
    assign src_fall  = !src_level && src_level_q;

    // Previous level of the selected source.
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
            src_level_q <= 1'b0;
        else
            src_level_q <= src_level;
    end

    // A falling edge must be seen after enabling before rises count.
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i || !counter_on || !clock_source_select)
            armed <= 1'b0;
        else if (src_fall)
            armed <= 1'b1;
    end

    // ============================================================
    // Instruction clock: reference divided by four, stopped in sleep.
    logic [1:0] instr_div;
    logic       instr_tick;

    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
            instr_div <= 2'h0;
        else
            instr_div <= instr_div + 2'h1;
    end

    assign instr_tick = (instr_div == `TSC_INSTR_LAST) && !sleep_i;

    // ============================================================
    // Prescaler
    tsc_pre_if pre_bus ();

    // External edges reach the prescaler even in sleep.
    assign pre_bus.edge_in = counter_on &&
                             (clock_source_select ? (src_rise && armed) : instr_tick);
    assign pre_bus.clear   = wr_lo || wr_hi;
    assign pre_bus.sel     = prescale_field;

    tsc_prescaler u_prescaler (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .pre       (pre_bus)
    );

    // ============================================================
    // Synchronisation stage after the prescaler
    logic sync_tick;
    logic inc;

    // The resynchronising stage is shut off in sleep.
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
            sync_tick <= 1'b0;
        else
            sync_tick <= pre_bus.tick && !sleep_i;
    end

    // Async counting takes the tick directly and keeps running in sleep.
    assign inc = async_mode ? pre_bus.tick :
                 (clock_source_select ? sync_tick : pre_bus.tick);

    // ============================================================
    // Special event trigger
    logic cmp_match;
    logic cmp_match_q;
    logic trig;

    assign cmp_match = (cmp_mode == `TSC_CMP_MODE_TRIG) && (count == {cmp_hi, cmp_lo});
    assign trig      = cmp_match && !cmp_match_q;

    // Remembers the match so one compare hit gives one trigger.
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
            cmp_match_q <= 1'b0;
        else
            cmp_match_q <= cmp_match;
    end

    // Conversion start pulse when the converter is enabled.
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
            adc_start_o <= 1'b0;
        else
            adc_start_o <= trig && adc_enable_i;
    end

    // ============================================================
    // Count register, left without reset so it survives every reset.
    logic wrap;

    assign wrap = inc && (count == 16'hffff);

    // Writes win over the trigger and the increment in the same cycle.
    always_ff @(posedge ref_clk_i)
    begin
        if (wr_lo)
            count[7:0] <= writedata_i[7:0];
        else if (wr_hi)
            count[15:8] <= writedata_i[7:0];
        else if (trig && !async_mode)
            count <= 16'h0000;
        else if (inc)
            count <= count + 16'h0001;
    end

    // ============================================================
    // Overflow flag: set on wrap, write one to clear, set wins.
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i || soft_rst_i)
            ovf_flag <= 1'b0;
        else if (wrap && !wr_lo && !wr_hi && !(trig && !async_mode))
            ovf_flag <= 1'b1;
        else if (wr_stat && writedata_i[`TSC_BIT_OVF])
            ovf_flag <= 1'b0;
    end

    // Flag drives the interrupt line, which also serves as wake-up.
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i || soft_rst_i)
            overflow_irq_o <= 1'b0;
        else
            overflow_irq_o <= ovf_flag;
    end

    // ============================================================
    // Control register: cleared only by power-on reset.
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
            control <= `TSC_CONTROL_RESET;
        else if (wr_ctl)
            control <= {1'b0, writedata_i[5:0]};
    end

    // Crystal oscillator enable follows control bit 3.
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
            osc_enable_o <= 1'b0;
        else
            osc_enable_o <= crystal_osc_enable;
    end

    // The count is a usable time base only outside asynchronous mode.
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
            timebase_valid_o <= 1'b0;
        else
            timebase_valid_o <= !async_mode;
    end

    // ============================================================
    // Compare registers
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            cmp_lo   <= 8'h00;
            cmp_hi   <= 8'h00;
            cmp_mode <= `TSC_CMP_MODE_RESET;
        end
        else
        begin
            if (wr_cmp_lo)
                cmp_lo <= writedata_i[7:0];
            if (wr_cmp_hi)
                cmp_hi <= writedata_i[7:0];
            if (wr_mode)
                cmp_mode <= writedata_i[3:0];
        end
    end

    // ============================================================
    // Read mux, sampled from registered state so bytes are never torn.
    logic [31:0] rd_value;

    always_comb
    begin
        rd_value = 32'h0;
        if (address_i == `TSC_OFS_COUNT_LO)
            rd_value = {24'h0, count[7:0]};
        else if (address_i == `TSC_OFS_COUNT_HI)
            rd_value = {24'h0, count[15:8]};
        else if (address_i == `TSC_OFS_CONTROL)
            rd_value = {25'h0, control};
        else if (address_i == `TSC_OFS_CMP_LO)
            rd_value = {24'h0, cmp_lo};
        else if (address_i == `TSC_OFS_CMP_HI)
            rd_value = {24'h0, cmp_hi};
        else if (address_i == `TSC_OFS_CMP_MODE)
            rd_value = {28'h0, cmp_mode};
        else if (address_i == `TSC_OFS_STATUS)
            rd_value = {31'h0, ovf_flag};
    end

    // ============================================================
    // Avalon-MM slave: one wait cycle, then the answer cycle.
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i || soft_rst_i)
        begin
            bus_state     <= tsc_pkg::TSC_BUS_IDLE;
            waitrequest_o <= 1'b1;
            readdata_o    <= 32'h0000_0000;
        end
        else
        begin
            case (bus_state)
                tsc_pkg::TSC_BUS_IDLE:
                begin
                    if (read_i || write_i)
                    begin
                        bus_state     <= tsc_pkg::TSC_BUS_ANSWER;
                        waitrequest_o <= 1'b0;
                        readdata_o    <= read_i ? rd_value : 32'h0000_0000;
                    end
                end
                tsc_pkg::TSC_BUS_ANSWER:
                begin
                    bus_state     <= tsc_pkg::TSC_BUS_IDLE;
                    waitrequest_o <= 1'b1;
                end
                default:
                begin
                    bus_state     <= tsc_pkg::TSC_BUS_IDLE;
                    waitrequest_o <= 1'b1;
                end
            endcase
        end
    end

endmodule // tsc_timer
`default_nettype wire

// ---- verilog/tsc_map.svh ----
// Register offsets, field positions, reset values and timing counts of the 16-bit timer.
//
// Function
// - Counter mode counts rising edges of crystal pin if enabled, else external pin.
// - Sync mode resynchronises after the prescaler; prescaler counts raw external edges.
// - Synchronised counter mode holds the count in sleep; prescaler keeps counting.
// - Sync disabled: count unsynchronised, runs in sleep, overflow can wake processor.
// - Asynchronous counter mode offers no time base to capture or compare.
// - Byte reads during asynchronous counting always return a clean byte.
// - Crystal enable bit (control bit 3) starts low-power 32.768 kHz oscillator.
// - Compare mode 1011 trigger resets counter and starts conversion if enabled.
// - A trigger reset never sets the overflow flag.
// - Trigger reset is guaranteed only in timer or synchronised counter mode.
// - A count write in the trigger cycle wins over the trigger reset.
// - With trigger reset, the compare pair acts as the counter period.
// - Count bytes are never cleared by any reset, only by the trigger.
// - Control resets to 00h on power-on or brown-out only.
// - Any write to a count byte clears the prescaler.
// - Count runs 0000h to FFFFh, wraps, and sets the overflow flag.
// - Prescale field 11/10/01/00 divides by 8/4/2/1.
// - After enabling counter mode, one falling edge precedes the first counted rise.
// - Clock select cleared counts the instruction clock, Fosc/4, ignoring sync disable.
`ifndef TSC_MAP_SVH
`define TSC_MAP_SVH

// ============================================================
// Register byte offsets
`define TSC_OFS_COUNT_LO   5'h00
`define TSC_OFS_COUNT_HI   5'h04
`define TSC_OFS_CONTROL    5'h08
`define TSC_OFS_CMP_LO     5'h0c
`define TSC_OFS_CMP_HI     5'h10
`define TSC_OFS_CMP_MODE   5'h14
`define TSC_OFS_STATUS     5'h18

// ============================================================
// Control field positions and reset values
`define TSC_BIT_ON         0
`define TSC_BIT_CS         1
`define TSC_BIT_SYNC_DIS   2
`define TSC_BIT_OSC_EN     3
`define TSC_BIT_PS_LO      4
`define TSC_BIT_PS_HI      5
`define TSC_BIT_OVF        0
`define TSC_CONTROL_RESET  7'h00
`define TSC_CMP_MODE_RESET 4'h0
`define TSC_CMP_MODE_TRIG  4'hb

// ============================================================
// Timing: the instruction clock is the reference clock divided by four.
`define TSC_INSTR_LAST     2'h3

`endif

// ---- verilog/tsc_pkg.sv ----
// Types shared by the 16-bit timer modules.
`default_nettype none
package tsc_pkg;

    // ============================================================
    // Bus slave states, one-hot.
    typedef enum logic [1:0] {
        TSC_BUS_IDLE   = 2'b01,
        TSC_BUS_ANSWER = 2'b10
    } tsc_bus_state_t;

    typedef logic [15:0] tsc_count_t;

endpackage
`default_nettype wire

// ---- verilog/tsc_pre_if.sv ----
// Interface between the timer core and its prescaler.
`timescale 1ns/1ps
`default_nettype none
interface tsc_pre_if;
    logic       edge_in;
    logic       clear;
    logic [1:0] sel;
    logic       tick;

    // The core feeds edges and settings and takes the divided tick.
    modport core (output edge_in, output clear, output sel, input tick);
    modport pre  (input edge_in, input clear, input sel, output tick);
endinterface
`default_nettype wire

// ---- verilog/tsc_sync2.sv ----
// Two-flop synchroniser for a pin level.
`timescale 1ns/1ps
`default_nettype none
module tsc_sync2 (
    input  wire logic ref_clk_i,
    input  wire logic d_i,
    output var  logic q_o
);
    logic stage1;

    // Only the second flop reads the first.
    always_ff @(posedge ref_clk_i)
    begin
        stage1 <= d_i;
        q_o    <= stage1;
    end
endmodule // tsc_sync2
`default_nettype wire

// ---- verilog/tsc_prescaler.sv ----
// Edge prescaler dividing by 1, 2, 4 or 8.
`timescale 1ns/1ps
`default_nettype none
module tsc_prescaler (
    input  wire logic ref_clk_i,
    input  wire logic rst_i,
    tsc_pre_if.pre    pre
);
    logic [2:0] cnt;
    logic [2:0] mask;

    // Mask of low bits that must be full before a tick passes.
    always_comb
    begin
        case (pre.sel)
            2'h0:    mask = 3'h0;
            2'h1:    mask = 3'h1;
            2'h2:    mask = 3'h3;
            default: mask = 3'h7;
        endcase
    end

    // The tick is the edge that completes a full prescale period.
    assign pre.tick = pre.edge_in && ((cnt & mask) == mask);

    // Counts every input edge; count writes clear it.
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i || pre.clear)
            cnt <= 3'h0;
        else if (pre.edge_in)
            cnt <= cnt + 3'h1;
    end
endmodule // tsc_prescaler
`default_nettype wire

// ---- verif/tsc_timer_checker.sv ----
// Concurrent checks on the ports of the 16-bit timer top.
`timescale 1ns/1ps
`default_nettype none
module tsc_timer_checker (
    input wire logic        ref_clk_i,
    input wire logic        rst_i,
    input wire logic        soft_rst_i,
    input wire logic        adc_enable_i,
    input wire logic [4:0]  address_i,
    input wire logic        read_i,
    input wire logic        write_i,
    input wire logic [3:0]  byteenable_i,
    input wire logic [31:0] writedata_i,
    input wire logic [31:0] readdata_o,
    input wire logic        waitrequest_o,
    input wire logic        osc_enable_o,
    input wire logic        overflow_irq_o,
    input wire logic        adc_start_o,
    input wire logic        timebase_valid_o
);
    logic       ctrl_wr;
    logic [7:0] ctrl_data;

    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    // ============================================================
    // Helper: remembers the last accepted control write.
    always_ff @(posedge ref_clk_i)
    begin
        ctrl_wr   <= write_i && !waitrequest_o && address_i == 5'h08 && byteenable_i[0];
        ctrl_data <= writedata_i[7:0];
    end

    // ============================================================
    // Bus handshake and register reads.
    take_answer_a: assert property (disable iff (rst_i || soft_rst_i)
        (read_i || write_i) && waitrequest_o |=> !waitrequest_o) else $error("answer late");
    answer_one_cycle_a: assert property (disable iff (rst_i || soft_rst_i)
        !waitrequest_o |=> waitrequest_o) else $error("answer too long");
    idle_quiet_a: assert property (!read_i && !write_i && waitrequest_o |=> waitrequest_o)
        else $error("answer without request");
    unmapped_zero_a: assert property (read_i && !waitrequest_o && address_i > 5'h18
        |-> readdata_o == 32'h0) else $error("unmapped read not zero");
    ctrl_top_zero_a: assert property (read_i && !waitrequest_o && address_i == 5'h08
        |-> readdata_o[31:6] == 26'h0) else $error("control upper bits not zero");
    reset_values_a: assert property ($fell(rst_i) |-> waitrequest_o && !osc_enable_o &&
        !overflow_irq_o && !adc_start_o) else $error("outputs wrong after reset");

    // ============================================================
    // Timer behaviour seen at the outputs.
    osc_follow_a: assert property (ctrl_wr |-> ##[0:1] osc_enable_o == ctrl_data[3])
        else $error("oscillator enable does not follow control");
    async_timebase_a: assert property (ctrl_wr
        |-> ##[0:1] timebase_valid_o == !(ctrl_data[1] && ctrl_data[2]))
        else $error("time base valid wrong for mode");
    adc_pulse_a: assert property (adc_start_o |-> $past(adc_enable_i) ##1 !adc_start_o)
        else $error("conversion start wrong");
    irq_holds_a: assert property (disable iff (rst_i || soft_rst_i)
        overflow_irq_o && !write_i && !$past(write_i) |=> overflow_irq_o)
        else $error("overflow flag dropped");
endmodule // tsc_timer_checker

bind tsc_timer tsc_timer_checker chk_u (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .soft_rst_i(soft_rst_i), .adc_enable_i(adc_enable_i),
    .address_i(address_i), .read_i(read_i), .write_i(write_i), .byteenable_i(byteenable_i),
    .writedata_i(writedata_i), .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
    .osc_enable_o(osc_enable_o), .overflow_irq_o(overflow_irq_o),
    .adc_start_o(adc_start_o), .timebase_valid_o(timebase_valid_o));
`default_nettype wire

// ---- verif/tsc_pin_model.sv ----
// Model of the external clock source and watch crystal feeding the timer pins.
`timescale 1ns/1ps
`default_nettype none
module tsc_pin_model #(
    parameter int HALF = 4
) (
    input  wire logic       ref_clk_i,
    input  wire logic       rst_i,
    input  wire logic       start_i,
    input  wire logic       sel_osc_i,
    input  wire logic [3:0] pulses_i,
    output var  logic       busy_o,
    output var  logic       ext_clock_pin_o,
    output var  logic       osc_input_pin_o
);
    logic [7:0] left;
    int         tick;
    logic       level;

    // Makes a burst of slow pulses; the pin rests low between bursts.
    always @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            busy_o <= 1'h0;
            level  <= 1'h0;
            left   <= 8'h00;
            tick   <= 0;
        end
        else if (!busy_o)
        begin
            if (start_i)
            begin
                busy_o <= 1'h1;
                left   <= {3'h0, pulses_i, 1'h0};
                tick   <= 0;
            end
        end
        else if (tick != HALF - 1)
            tick <= tick + 1;
        else
        begin
            tick <= 0;
            if (left == 8'h00)
                busy_o <= 1'h0;
            else
            begin
                level <= !level;
                left  <= left - 8'h01;
            end
        end
    end

    // Only the chosen pin carries the pulses, the other stays low.
    assign ext_clock_pin_o = level & !sel_osc_i;
    assign osc_input_pin_o = level & sel_osc_i;
endmodule // tsc_pin_model
`default_nettype wire

// ---- verif/tsc_timer_test.sv ----
// Self-checking testbench of the 16-bit timer.
`timescale 1ns/1ps
`default_nettype none
`include "tsc_map.svh"
module tsc_timer_test;
    logic        ref_clk_i = 1'h0, rst_i = 1'h1, soft_rst_i = 1'h0, sleep_i = 1'h0;
    logic        adc_enable_i = 1'h0, read_i = 1'h0, write_i = 1'h0;
    logic [4:0]  address_i = 5'h00;
    logic [31:0] writedata_i = 32'h0, readdata_o;
    logic        waitrequest_o, osc_enable_o, overflow_irq_o, adc_start_o, timebase_valid_o;
    logic        ext_pin, osc_pin, pm_busy, pm_start = 1'h0, pm_osc = 1'h0;
    logic [7:0]  q;
    int          bad_count = 0, compares = 0;

    // Clock of 40 ns period.
    always #20 ref_clk_i = ~ref_clk_i;

    tsc_timer dut_u (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .soft_rst_i(soft_rst_i),
        .sleep_i(sleep_i), .adc_enable_i(adc_enable_i), .ext_clock_pin_i(ext_pin),
        .osc_input_pin_i(osc_pin), .address_i(address_i), .read_i(read_i),
        .write_i(write_i), .byteenable_i(4'hf), .writedata_i(writedata_i),
        .readdata_o(readdata_o), .waitrequest_o(waitrequest_o), .osc_enable_o(osc_enable_o),
        .overflow_irq_o(overflow_irq_o), .adc_start_o(adc_start_o),
        .timebase_valid_o(timebase_valid_o));
    tsc_pin_model pm_u (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .start_i(pm_start),
        .sel_osc_i(pm_osc), .pulses_i(4'h6), .busy_o(pm_busy), .ext_clock_pin_o(ext_pin),
        .osc_input_pin_o(osc_pin));

    // ============================================================
    // Reporting and bus access.
    task tally_and_finish;
        $display("TB: compares=%0d bad_count=%0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp)
        begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    task chk_rng(input string name, input logic [7:0] lo, input logic [7:0] hi,
                 input logic [7:0] got);
        compares++;
        if (^got === 1'bx || got < lo || got > hi)
        begin
            bad_count++;
            $display("ERROR %s expected %h..%h seen %h", name, lo, hi, got);
        end
    endtask
    task give_up(input string name);
        chk(name, 8'h01, 8'h00);
        tally_and_finish;
    endtask
    task bus(input logic w, input logic [4:0] a, input logic [7:0] d = 8'h00);
        int n;
        n = 0;
        read_i <= !w;
        write_i <= w;
        address_i <= a;
        writedata_i <= {24'h0, d};
        do begin @(posedge ref_clk_i); n++; end while (waitrequest_o !== 1'h0 && n < 40);
        q = readdata_o[7:0];
        read_i <= 1'h0;
        write_i <= 1'h0;
        @(posedge ref_clk_i);
        if (n >= 40) give_up("bus answer");
    endtask

    // ============================================================
    // Scenarios.
    task t_reset;
        bus(1, `TSC_OFS_COUNT_LO, 8'h5a);
        bus(1, `TSC_OFS_COUNT_HI, 8'ha5);
        bus(1, `TSC_OFS_CONTROL, 8'h38);
        soft_rst_i <= 1'h1;
        repeat (2) @(posedge ref_clk_i);
        soft_rst_i <= 1'h0;
        @(posedge ref_clk_i);
        bus(0, `TSC_OFS_CONTROL); chk("control after other reset", 8'h38, q);
        rst_i <= 1'h1;
        repeat (3) @(posedge ref_clk_i);
        rst_i <= 1'h0;
        @(posedge ref_clk_i);
        bus(0, `TSC_OFS_CONTROL); chk("control after power reset", 8'h00, q);
        bus(0, `TSC_OFS_COUNT_LO); chk("count low kept", 8'h5a, q);
        bus(0, `TSC_OFS_COUNT_HI); chk("count high kept", 8'ha5, q);
        bus(0, 5'h1c); chk("unmapped read", 8'h00, q);
        $display("TB: reset test done");
    endtask
    task t_prescale;
        for (int ps = 0; ps < 4; ps++)
        begin
            bus(1, `TSC_OFS_COUNT_LO, 8'h00);
            bus(1, `TSC_OFS_COUNT_HI, 8'h00);
            bus(1, `TSC_OFS_CONTROL, 8'h05 | 8'(ps << 4));
            repeat (40 * (1 << ps) - 3) @(posedge ref_clk_i);
            bus(1, `TSC_OFS_CONTROL, 8'h00);
            bus(0, `TSC_OFS_COUNT_LO); chk_rng("timer count", 8'h09, 8'h0b, q);
        end
        $display("TB: prescale test done");
    endtask
    task t_overflow;
        bus(1, `TSC_OFS_COUNT_LO, 8'hfe);
        bus(1, `TSC_OFS_COUNT_HI, 8'hff);
        bus(1, `TSC_OFS_STATUS, 8'h01);
        bus(1, `TSC_OFS_CONTROL, 8'h01);
        repeat (20) @(posedge ref_clk_i);
        bus(1, `TSC_OFS_CONTROL, 8'h00);
        bus(0, `TSC_OFS_COUNT_HI); chk("count high wrapped", 8'h00, q);
        bus(0, `TSC_OFS_COUNT_LO); chk_rng("count low wrapped", 8'h02, 8'h05, q);
        bus(0, `TSC_OFS_COUNT_HI); chk("count high again", 8'h00, q);
        bus(0, `TSC_OFS_STATUS); chk("overflow flag set", 8'h01, q);
        chk("overflow output", 8'h01, {7'h0, overflow_irq_o});
        bus(1, `TSC_OFS_STATUS, 8'h01);
        bus(0, `TSC_OFS_STATUS); chk("overflow flag cleared", 8'h00, q);
        $display("TB: overflow test done");
    endtask
    task t_trigger;
        int n;
        bus(1, `TSC_OFS_CMP_LO, 8'h05);
        bus(1, `TSC_OFS_CMP_HI, 8'h00);
        bus(1, `TSC_OFS_CMP_MODE, 8'h0b);
        bus(1, `TSC_OFS_COUNT_LO, 8'h00);
        bus(1, `TSC_OFS_COUNT_HI, 8'h00);
        for (int e = 1; e >= 0; e--)
        begin
            adc_enable_i <= e[0];
            bus(1, `TSC_OFS_CONTROL, 8'h01);
            n = 0;
            repeat (200) begin @(posedge ref_clk_i); if (adc_start_o === 1'h1) n++; end
            bus(1, `TSC_OFS_CONTROL, 8'h00);
            chk_rng("conversion starts", e ? 8'h07 : 8'h00, e ? 8'h0b : 8'h00, n[7:0]);
        end
        bus(0, `TSC_OFS_STATUS); chk("no flag from trigger", 8'h00, q);
        bus(0, `TSC_OFS_COUNT_LO); chk_rng("count within period", 8'h00, 8'h05, q);
        bus(1, `TSC_OFS_CMP_MODE, 8'h00);
        $display("TB: trigger test done");
    endtask
    task run_cnt(input logic [7:0] ctrl, input logic osc, input logic slp,
                 input logic [7:0] exp);
        int n;
        bus(1, `TSC_OFS_CONTROL, 8'h00);
        bus(1, `TSC_OFS_COUNT_LO, 8'h00);
        bus(1, `TSC_OFS_COUNT_HI, 8'h00);
        sleep_i <= slp;
        pm_osc <= osc;
        bus(1, `TSC_OFS_CONTROL, ctrl);
        if (ctrl[3]) repeat (8) @(posedge ref_clk_i);
        pm_start <= 1'h1;
        @(posedge ref_clk_i);
        pm_start <= 1'h0;
        n = 0;
        do begin @(posedge ref_clk_i); n++; end while (pm_busy !== 1'h0 && n < 200);
        if (n >= 200) give_up("pin burst");
        repeat (8) @(posedge ref_clk_i);
        sleep_i <= 1'h0;
        bus(1, `TSC_OFS_CONTROL, 8'h00);
        bus(0, `TSC_OFS_COUNT_LO); chk("pulses counted", exp, q);
        $display("TB: counter run done");
    endtask

    // Main sequence.
    initial
    begin
        repeat (10) @(posedge ref_clk_i);
        rst_i <= 1'h0;
        @(posedge ref_clk_i);
        t_reset;
        t_prescale;
        t_overflow;
        t_trigger;
        run_cnt(8'h03, 1'h0, 1'h0, 8'h05);
        run_cnt(8'h0b, 1'h1, 1'h0, 8'h05);
        run_cnt(8'h0b, 1'h0, 1'h0, 8'h00);
        run_cnt(8'h03, 1'h0, 1'h1, 8'h00);
        run_cnt(8'h07, 1'h0, 1'h1, 8'h05);
        tally_and_finish;
    end
endmodule // tsc_timer_test
`default_nettype wire
